// File: cscc_defs.svh
// constants for the card spi command control block
`ifndef CSCC_DEFS_SVH
`define CSCC_DEFS_SVH
// command indices the control logic looks at
`define CSCC_CMD_RESET      6'h00
`define CSCC_CMD_INIT_POLL  6'h01
`define CSCC_CMD_SEND_CSPEC 6'h09
`define CSCC_CMD_SEND_IDENT 6'h0a
`define CSCC_CMD_STOP       6'h0c
`define CSCC_CMD_READ_COND  6'h3a
// frame layout
`define CSCC_FRAME_BITS     6'd47
// response status bit positions
`define CSCC_R1_IDLE        0
`define CSCC_R1_ILLEGAL     2
`define CSCC_R1_CRC         3
`define CSCC_R1_RANGE       6
// response lengths in bits, gap byte included
`define CSCC_LEN_R1         8'd16
`define CSCC_LEN_R3         8'd48
`define CSCC_LEN_DATA       8'd176
`define CSCC_GAP_BYTE       8'hff
`define CSCC_START_TOKEN    8'hfe
// command maps: bit n set means command n belongs to that group
`define CSCC_BASIC_CMDS     64'h0c00_0000_0001_3743
`define CSCC_READ_CMDS      64'h0000_0000_0086_0000
`define CSCC_WRITE_CMDS     64'h0000_0000_0b00_0000
`define CSCC_PROT_CMDS      64'h0000_0000_7000_0000
`define CSCC_ERASE_CMDS     64'h0000_0058_0000_0000
`define CSCC_LOCK_CMDS      64'h0000_0400_0000_0000
`define CSCC_APP_CMDS       64'h0180_0000_0000_0000
// operation timeout is this multiple of the typical time
`define CSCC_TIMEOUT_FACTOR 10
`endif

// File: cscc_pkg.sv
// types and checksum functions for the card spi command control block
`default_nettype none
package cscc_pkg;
    typedef enum logic [1:0] {CSCC_ST_RX = 2'b01, CSCC_ST_TX = 2'b10} cscc_state_t;

    // crc7 over the first 40 frame bits, generator x^7+x^3+1
    function automatic logic [6:0] cscc_crc7(input logic [39:0] d);
        logic [6:0] c;
        logic       fb;
        c = 7'h00;
        for (int i = 39; i >= 0; i--)
        begin
            fb = d[i] ^ c[6];
            c  = {c[5:0], 1'b0} ^ (fb ? 7'h09 : 7'h00);
        end
        return c;
    endfunction

    // crc16 over a 16 byte register block, generator x^16+x^12+x^5+1
    function automatic logic [15:0] cscc_crc16(input logic [127:0] d);
        logic [15:0] c;
        logic        fb;
        c = 16'h0000;
        for (int i = 127; i >= 0; i--)
        begin
            fb = d[i] ^ c[15];
            c  = {c[14:0], 1'b0} ^ (fb ? 16'h1021 : 16'h0000);
        end
        return c;
    endfunction
endpackage
`default_nettype wire

// File: cscc_card.sv
// card-side spi command interpreter: frames, init polling, register reads, busy, errors
// Overview of operation
// - register read returns token, 16 bytes, crc16
// - identification read framed like card data read
// - after reset idle accepts only reset, poll, conditions
// - idle flag clears only after initialisation finishes
// - poll command ignores operand, returns no conditions
// - conditions read answered at any time
// - host may change or stop the clock
// - busy released only on a later clock edge
// - failed command crc sets crc flag
// - unsupported, barred, undefined commands flagged illegal
// - operations abandoned after ten typical times
// - prefetch overrun reported in stop response
// - frame is 48 bits with fixed field layout
// - six bytes, msb first, always with crc
// - class table gates commands in spi mode
// - busy holds data-out low while programming
`default_nettype none
`include "cscc_defs.svh"
module cscc_card
    import cscc_pkg::*;
#(
    parameter int INIT_CYCLES = 1000,   // internal initialisation length in clocks
    parameter int TYP_W       = 24      // width of the typical operation time
)(
    input  wire logic             clk_sys,               // system clock, 125 mhz
    input  wire logic             rst_n,                 // async reset, active low
    input  wire logic             spi_sclk,              // bus clock from host
    input  wire logic             spi_cs_n,              // chip select, active low
    input  wire logic             spi_mosi,              // command bits from host
    output logic                  spi_miso,              // data-out line level
    output logic                  spi_miso_oe,           // data-out driven while high
    input  wire logic [127:0]     cid_data,              // card_identification block
    input  wire logic [127:0]     csd_data,              // card_specific_data block
    input  wire logic [31:0]      ocr_data,              // operating_conditions word
    input  wire logic [11:0]      class_support,         // supported command classes
    input  wire logic             prog_busy,             // programming in progress
    input  wire logic             prefetch_overrun,      // read-ahead passed last address
    input  wire logic             op_start,              // timed operation begins, pulse
    input  wire logic             op_done,               // timed operation ends, pulse
    input  wire logic [TYP_W-1:0] op_typ_cycles,         // typical time of the operation
    output logic                  in_idle,               // card in idle state
    output logic                  cmd_valid,             // legal command taken, pulse
    output logic [5:0]            cmd_index,             // index of last legal command
    output logic [31:0]           cmd_arg,               // argument of last legal command
    output logic                  command_crc_fail_flag, // last frame failed crc
    output logic                  illegal_flag,          // last frame was illegal
    output logic                  address_range_fault,   // overrun awaiting stop command
    output logic                  op_abort,              // operation abandoned, pulse
    output logic                  op_timeout_err         // sticky timeout error
);
    localparam int LIM_W = TYP_W + 4;

    // pin synchronisers; bit 0 feeds only bit 1
    logic [2:0] sclk_q;
    logic [1:0] cs_q;
    logic [1:0] mosi_q;
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sclk_q <= 3'h0;
            cs_q   <= 2'h3;
            mosi_q <= 2'h3;
        end
        else
        begin
            sclk_q <= {sclk_q[1:0], spi_sclk};
            cs_q   <= {cs_q[0], spi_cs_n};
            mosi_q <= {mosi_q[0], spi_mosi};
        end
    end

    // edges found by sampling, so any host rate well below clk_sys or a stopped clock is fine
    wire sclk_rise = sclk_q[1] & ~sclk_q[2];
    wire sclk_fall = ~sclk_q[1] & sclk_q[2];
    wire sel       = ~cs_q[1];

    cscc_state_t  state;
    logic [47:0]  rx_sh;
    logic [5:0]   rx_cnt;
    logic         frame_done;
    logic [175:0] tx_sh;
    logic [7:0]   tx_left;
    logic         busy_hold;
    logic [31:0]  init_cnt;
    logic [LIM_W-1:0] op_cnt;
    logic [LIM_W-1:0] op_lim;
    logic         op_run;

    // frame fields, msb first; start bit is the first zero seen
    wire [5:0]  rx_idx  = rx_sh[45:40];
    wire [31:0] rx_arg  = rx_sh[39:8];
    wire        crc_ok  = (cscc_crc7(rx_sh[47:8]) == rx_sh[7:1])
                          && rx_sh[46] && rx_sh[0];
    wire        init_fin = (init_cnt == 32'(INIT_CYCLES));

    // legal map: fixed spi set, optional classes gated by the class table
    wire [63:0] legal_map = `CSCC_BASIC_CMDS
        | (`CSCC_READ_CMDS  & {64{class_support[2]}})
        | (`CSCC_WRITE_CMDS & {64{class_support[4]}})
        | (`CSCC_ERASE_CMDS & {64{class_support[5]}})
        | (`CSCC_PROT_CMDS  & {64{class_support[6]}})
        | (`CSCC_LOCK_CMDS  & {64{class_support[7]}})
        | (`CSCC_APP_CMDS   & {64{class_support[8]}});
    wire idle_ok = (rx_idx == `CSCC_CMD_RESET) || (rx_idx == `CSCC_CMD_INIT_POLL)
                   || (rx_idx == `CSCC_CMD_READ_COND);
    wire legal   = crc_ok && (in_idle ? idle_ok : legal_map[rx_idx]);
    wire illegal = crc_ok && !legal;

    // idle entered on reset command, left on a poll once init is over
    wire next_idle = (crc_ok && rx_idx == `CSCC_CMD_RESET) ? 1'b1 :
                     (legal && rx_idx == `CSCC_CMD_INIT_POLL && init_fin) ? 1'b0 :
                     in_idle;
    wire rng_rep = address_range_fault && legal && rx_idx == `CSCC_CMD_STOP;
    wire [7:0] r1 = {1'b0, rng_rep, 2'b00, !crc_ok, illegal, 1'b0, next_idle};

    // response frames; the poll command gets a bare status byte, operand unused
    wire is_reg = legal && (rx_idx == `CSCC_CMD_SEND_CSPEC || rx_idx == `CSCC_CMD_SEND_IDENT);
    wire is_ocr = legal && rx_idx == `CSCC_CMD_READ_COND;
    wire [127:0] blk = (rx_idx == `CSCC_CMD_SEND_CSPEC) ? csd_data : cid_data;
    wire [175:0] frame_data = {`CSCC_GAP_BYTE, r1, `CSCC_GAP_BYTE, `CSCC_START_TOKEN,
                               blk, cscc_crc16(blk)};
    wire [175:0] frame_r3 = {`CSCC_GAP_BYTE, r1, ocr_data, 128'h0};
    wire [175:0] frame_r1 = {`CSCC_GAP_BYTE, r1, 160'h0};
    wire [175:0] next_frame = is_reg ? frame_data : is_ocr ? frame_r3 : frame_r1;
    wire [7:0]   next_len   = is_reg ? `CSCC_LEN_DATA : is_ocr ? `CSCC_LEN_R3 : `CSCC_LEN_R1;

    // receive shifter; commands are ignored while busy or sending
    wire rx_go = sel && state == CSCC_ST_RX && !busy_hold && sclk_rise
                 && !(rx_cnt == 6'd0 && mosi_q[1]);
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_sh      <= 48'h0;
            rx_cnt     <= 6'd0;
            frame_done <= 1'b0;
        end
        else
        begin
            frame_done <= rx_go && rx_cnt == `CSCC_FRAME_BITS;
            if (!sel)
                rx_cnt <= 6'd0;
            else if (rx_go)
            begin
                rx_sh  <= {rx_sh[46:0], mosi_q[1]};
                rx_cnt <= (rx_cnt == `CSCC_FRAME_BITS) ? 6'd0 : rx_cnt + 6'd1;
            end
        end
    end

    // transmit on falling edges; the host must keep clocking to drain it
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state   <= CSCC_ST_RX;
            tx_sh   <= 176'h0;
            tx_left <= 8'd0;
        end
        else if (!sel)
            state <= CSCC_ST_RX;
        else if (state == CSCC_ST_RX && frame_done)
        begin
            state   <= CSCC_ST_TX;
            tx_sh   <= next_frame;
            tx_left <= next_len;
        end
        else if (state == CSCC_ST_TX && sclk_fall)
        begin
            tx_sh   <= {tx_sh[174:0], 1'b0};
            tx_left <= tx_left - 8'd1;
            if (tx_left == 8'd1)
                state <= CSCC_ST_RX;
        end
    end

    // busy is dropped only on a bus clock edge, so a stopped clock keeps the line low
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            busy_hold <= 1'b0;
        else if (prog_busy)
            busy_hold <= 1'b1;
        else if (sclk_fall)
            busy_hold <= 1'b0;
    end

    // data-out line; released when deselected even if still busy
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            spi_miso    <= 1'b1;
            spi_miso_oe <= 1'b0;
        end
        else
        begin
            spi_miso_oe <= sel;
            if (busy_hold)
                spi_miso <= 1'b0;
            else if (sclk_fall)
                spi_miso <= (state == CSCC_ST_TX) ? tx_sh[175] : 1'b1;
        end
    end

    // command results and idle state
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            in_idle               <= 1'b1;
            init_cnt              <= 32'd0;
            cmd_valid             <= 1'b0;
            cmd_index             <= 6'h00;
            cmd_arg               <= 32'h0;
            command_crc_fail_flag <= 1'b0;
            illegal_flag          <= 1'b0;
            address_range_fault   <= 1'b0;
        end
        else
        begin
            cmd_valid <= frame_done && state == CSCC_ST_RX && legal;
            if (frame_done && state == CSCC_ST_RX)
            begin
                in_idle               <= next_idle;
                command_crc_fail_flag <= !crc_ok;
                illegal_flag          <= illegal;
                if (legal)
                begin
                    cmd_index <= rx_idx;
                    cmd_arg   <= rx_arg;
                end
            end
            if (frame_done && crc_ok && rx_idx == `CSCC_CMD_RESET)
                init_cnt <= 32'd0;
            else if (!init_fin)
                init_cnt <= init_cnt + 32'd1;
            // a new overrun wins over the report that clears the old one
            if (prefetch_overrun)
                address_range_fault <= 1'b1;
            else if (frame_done && state == CSCC_ST_RX && rng_rep)
                address_range_fault <= 1'b0;
        end
    end

    // operation watchdog at ten times the typical time
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            op_run         <= 1'b0;
            op_cnt         <= '0;
            op_lim         <= '0;
            op_abort       <= 1'b0;
            op_timeout_err <= 1'b0;
        end
        else
        begin
            // the pulse itself stops the run, so it must not repeat on the next cycle
            op_abort <= op_run && !op_abort && !op_done && op_cnt >= op_lim;
            if (op_start)
            begin
                op_run <= 1'b1;
                op_cnt <= '0;
                op_lim <= LIM_W'(op_typ_cycles) * LIM_W'(`CSCC_TIMEOUT_FACTOR);
            end
            else if (op_done || op_abort)
                op_run <= 1'b0;
            else if (op_run)
                op_cnt <= op_cnt + 1'b1;
            if (op_abort)
                op_timeout_err <= 1'b1;
            else if (cmd_valid && cmd_index == `CSCC_CMD_RESET)
                op_timeout_err <= 1'b0;
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    wire take = frame_done && state == CSCC_ST_RX;
    chk_reset_enters_idle: assert property (take && crc_ok && rx_idx == 6'h00 |=> in_idle)
        else $error("reset command did not enter idle");
    chk_idle_only_poll: assert property (take && crc_ok && in_idle && !idle_ok
        |=> illegal_flag && tx_sh[160+`CSCC_R1_ILLEGAL]) else $error("idle accepted other cmd");
    chk_idle_exit_init: assert property ($fell(in_idle) |-> init_fin)
        else $error("idle cleared before init finished");
    chk_crc_fail_flag: assert property (take && !crc_ok
        |=> command_crc_fail_flag && tx_sh[160+`CSCC_R1_CRC]) else $error("crc fail not flagged");
    chk_undefined_cmd: assert property (take && crc_ok && rx_idx == 6'h2f |=> illegal_flag)
        else $error("undefined command accepted");
    chk_reg_read_len: assert property (take && is_reg |=> tx_left == `CSCC_LEN_DATA
        && tx_sh[151:144] == `CSCC_START_TOKEN) else $error("register block frame wrong");
    chk_cond_read_any: assert property (take && crc_ok && rx_idx == 6'h3a
        |=> tx_left == `CSCC_LEN_R3 && tx_sh[159:128] == $past(ocr_data))
        else $error("conditions word not returned");
    chk_busy_line_low: assert property (busy_hold |=> !spi_miso)
        else $error("data-out not low while busy");
    chk_busy_release: assert property ($fell(busy_hold) |-> $past(sclk_fall) && !$past(prog_busy))
        else $error("busy released without clock edge");
    chk_overrun_report: assert property (take && rng_rep && !prefetch_overrun
        |=> tx_sh[160+`CSCC_R1_RANGE] && !address_range_fault) else $error("overrun not reported");
    chk_timeout_abort: assert property (op_abort |=> op_timeout_err && !op_run)
        else $error("abort did not latch error");
    cov_reg_read: cover property (take && is_reg ##[1:1000] state == CSCC_ST_RX);
    cov_leave_idle: cover property ($fell(in_idle));
    cov_busy_done: cover property ($fell(busy_hold));
    cov_timeout: cover property (op_abort);
endmodule
`default_nettype wire

// File: cscc_host_model.sv
// spi host model that frames commands, clocks responses and stops its clock between frames
`default_nettype none
module cscc_host_model (
    output logic      spi_sclk,  // bus clock, idle low
    output logic      spi_cs_n,  // chip select, active low
    output logic      spi_mosi,  // command bits to the card
    input  wire logic miso_line  // resolved data-out wire level
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam realtime HALF = 62.5;

    initial
    begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b1;
    end

    // msb-first crc of width w over the low n bits of d
    function automatic logic [15:0] crc_calc(input logic [127:0] d, input int n, input int w,
                                             input logic [15:0] poly);
        logic [15:0] c;
        logic        fb;
        c = 16'h0000;
        for (int i = n - 1; i >= 0; i--)
        begin
            fb = d[i] ^ c[w-1];
            c  = ((c << 1) ^ (fb ? poly : 16'h0000)) & ((16'h0001 << w) - 16'h0001);
        end
        return c;
    endfunction

    // one bus clock: data set in the low phase, both sides sample on the rise
    task automatic bit_cycle(input logic b, output logic r);
        spi_mosi = b;
        #HALF spi_sclk = 1'b1;
        r = miso_line;
        #HALF spi_sclk = 1'b0;
    endtask

    task automatic clocks(input int n);
        logic r;
        for (int i = 0; i < n; i++)
            bit_cycle(1'b1, r);
    endtask

    // released mosi toggles so a stale level is never mistaken for data
    task automatic select(input logic on);
        spi_cs_n = !on;
        if (!on)
            spi_mosi = !spi_mosi;
        #HALF;
    endtask

    // send one command frame, then clock nresp response bits in
    task automatic xfer(input logic [5:0] idx, input logic [31:0] arg, input logic bad,
                        input int nresp, output logic [175:0] resp);
        logic [47:0] frame;
        logic [15:0] c;
        logic        r;
        frame[47:8] = {2'b01, idx, arg};
        c           = crc_calc({88'h0, frame[47:8]}, 40, 7, 16'h0009);
        frame[7:0]  = {c[6:0] ^ {6'h00, bad}, 1'b1};
        resp        = '0;
        select(1'b1);
        for (int i = 47; i >= 0; i--)
            bit_cycle(frame[i], r);
        for (int i = 0; i < nresp; i++)
        begin
            bit_cycle(1'b1, r);
            resp = {resp[174:0], r};
        end
        clocks(8);
        select(1'b0);
    endtask
endmodule
`default_nettype wire

// File: tb_top.sv
// self-checking bench for the card spi command interpreter
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int INIT_N = 3000;
    logic         clk_sys, rst_n, spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
    logic         miso_line, prog_busy, prefetch_overrun, op_start, op_done, in_idle;
    logic         cmd_valid, command_crc_fail_flag, illegal_flag, address_range_fault;
    logic         op_abort, op_timeout_err, seen;
    logic [127:0] cid_data, csd_data, blk;
    logic [31:0]  ocr_data, cmd_arg;
    logic [11:0]  class_support;
    logic [23:0]  op_typ_cycles;
    logic [5:0]   cmd_index;
    logic [5:0]   bad_cmds [3] = '{6'd20, 6'd47, 6'd35};
    logic [175:0] r;
    logic [15:0]  c16;
    int           mismatches, num_checks, n, valid_cnt, read_access, block_program;
    // card timing parameters in clk_sys cycles, giving the typical time fed to the card's watchdog
    localparam int access_time_param         = 3;
    localparam int access_clock_cycles_param = 2;
    localparam int write_speed_factor        = 2;
    localparam int erase_blocks              = 1;

    // legal commands taken, counted from the one-cycle pulse
    always @(posedge clk_sys)
        if (cmd_valid === 1'b1)
            valid_cnt <= valid_cnt + 1;

    // data-out has a pull-up once the card lets go of it
    assign miso_line = spi_miso_oe ? spi_miso : 1'b1;

    cscc_card #(.INIT_CYCLES(INIT_N), .TYP_W(24)) u_dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
        .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
        .cid_data(cid_data), .csd_data(csd_data), .ocr_data(ocr_data),
        .class_support(class_support), .prog_busy(prog_busy),
        .prefetch_overrun(prefetch_overrun), .op_start(op_start), .op_done(op_done),
        .op_typ_cycles(op_typ_cycles), .in_idle(in_idle), .cmd_valid(cmd_valid),
        .cmd_index(cmd_index), .cmd_arg(cmd_arg), .command_crc_fail_flag(command_crc_fail_flag),
        .illegal_flag(illegal_flag), .address_range_fault(address_range_fault),
        .op_abort(op_abort), .op_timeout_err(op_timeout_err));

    cscc_host_model u_host (
        .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .miso_line(miso_line));

    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    task automatic complete_run();
        if (mismatches == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic check(input logic [175:0] got, input logic [175:0] exp, input string what);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask

    task automatic cmd(input logic [5:0] idx, input logic [31:0] arg, input logic bad,
                       input int nresp, input logic [175:0] exp);
        logic [175:0] got;
        u_host.xfer(idx, arg, bad, nresp, got);
        check(got, exp, "card response");
    endtask

    // a hang is cut short well beyond the longest expected run
    initial
    begin
        repeat (80000) @(posedge clk_sys);
        mismatches++;
        complete_run();
    end

    initial
    begin
        rst_n = 1'b0;
        prog_busy = 1'b0;
        prefetch_overrun = 1'b0;
        op_start = 1'b0;
        op_done = 1'b0;
        cid_data = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210;
        csd_data = 128'h8e0f_3a00_5a5b_f000_1122_3344_5566_7788;
        ocr_data = 32'h80ff_8000;
        class_support = 12'h1d4; // erase class left out on purpose
        read_access = access_time_param + access_clock_cycles_param;
        block_program = read_access * write_speed_factor;
        op_typ_cycles = 24'(erase_blocks * block_program);
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        check(in_idle, 176'h1, "idle after reset");
        cmd(6'd17, 32'h0, 1'b0, 16, 176'hff05);
        cmd(6'd58, 32'h0, 1'b0, 48, {128'h0, 16'hff01, ocr_data});
        cmd(6'd0, 32'h0, 1'b0, 16, 176'hff01);
        cmd(6'd1, 32'hffff_ffff, 1'b0, 48, 176'hff01_ffff_ffff);
        // keep polling until the card reports that initialisation is over
        n = 0;
        r = '1;
        while (r[7:0] !== 8'h00 && n < 6)
        begin
            u_host.xfer(6'd1, 32'h1234_5678, 1'b0, 16, r);
            n++;
        end
        check(r, 176'hff00, "idle flag never cleared");
        check(in_idle, 176'h0, "idle output");
        cmd(6'd58, 32'h0, 1'b0, 48, {128'h0, 16'hff00, ocr_data});
        for (int i = 0; i < 2; i++)
        begin
            blk = i ? cid_data : csd_data;
            c16 = u_host.crc_calc(blk, 128, 16, 16'h1021);
            cmd(i ? 6'd10 : 6'd9, 32'h0, 1'b0, 176, {32'hff00_fffe, blk, c16});
        end
        for (int i = 0; i < 3; i++)
            cmd(bad_cmds[i], 32'h0, 1'b0, 16, 176'hff04);
        check(illegal_flag, 176'h1, "illegal flag");
        n = valid_cnt;
        cmd(6'd24, 32'h0000_0200, 1'b0, 16, 176'hff00);
        check(valid_cnt - n, 176'd1, "one command taken");
        check(cmd_index, 176'd24, "command index");
        check(cmd_arg, 176'h200, "command argument");
        cmd(6'd13, 32'h0, 1'b1, 16, 176'hff08);
        check(command_crc_fail_flag, 176'h1, "crc flag");
        @(posedge clk_sys);
        prefetch_overrun <= 1'b1;
        @(posedge clk_sys);
        prefetch_overrun <= 1'b0;
        @(negedge clk_sys);
        check(address_range_fault, 176'h1, "overrun pending");
        u_host.xfer(6'd12, 32'h0, 1'b0, 16, r);
        check(r, 176'hff40, "overrun in stop response");
        check(r & ~176'h40, 176'hff00, "stop status at end of memory");
        check(address_range_fault, 176'h0, "overrun cleared");
        cmd(6'd12, 32'h0, 1'b0, 16, 176'hff00);
        // busy with the bus clock stopped, released only by a later edge
        u_host.select(1'b1);
        @(posedge clk_sys);
        prog_busy <= 1'b1;
        repeat (20) @(negedge clk_sys);
        check(miso_line, 176'h0, "busy level");
        @(posedge clk_sys);
        prog_busy <= 1'b0;
        repeat (50) @(negedge clk_sys);
        check(miso_line, 176'h0, "busy held without edge");
        u_host.clocks(2);
        repeat (5) @(negedge clk_sys);
        check(miso_line, 176'h1, "busy released");
        u_host.select(1'b0);
        // a finished operation must not be abandoned
        @(posedge clk_sys);
        op_start <= 1'b1;
        @(posedge clk_sys);
        op_start <= 1'b0;
        repeat (50) @(posedge clk_sys);
        op_done <= 1'b1;
        @(posedge clk_sys);
        op_done <= 1'b0;
        seen = 1'b0;
        repeat (150) @(negedge clk_sys) seen = seen | op_abort;
        check(seen, 176'h0, "abort after completion");
        @(posedge clk_sys);
        op_start <= 1'b1;
        @(posedge clk_sys);
        op_start <= 1'b0;
        n = 0;
        while (op_abort !== 1'b1 && n < 200)
        begin
            @(negedge clk_sys);
            n++;
        end
        check(n >= 95 && n <= 105, 176'h1, "abort timing");
        @(negedge clk_sys);
        check(op_abort, 176'h0, "abort is one pulse");
        repeat (3) @(negedge clk_sys);
        check(op_timeout_err, 176'h1, "timeout error");
        cmd(6'd0, 32'h0, 1'b0, 16, 176'hff01);
        check(op_timeout_err, 176'h0, "timeout error cleared");
        complete_run();
    end
endmodule
`default_nettype wire
